// >>> rrs_req_sideband.sv
// requester request sideband decode, credits, message, interrupt,
// flow-control and configuration ports with an apb register slave
// assumes all user inputs come from logic on I_CLK
`timescale 1ns/1ps
`default_nettype none
module rrs_req_sideband import rrs_pkg::*; #(
    parameter int DATA_W = 128,
    parameter int UW = 60,
    parameter int NPH_INIT = 32,
    parameter int NPD_INIT = 256,
    parameter int TAG_INIT = 32,
    parameter logic [7:0] P_HDR = 8'h20,
    parameter logic [11:0] P_DATA = 12'h100,
    parameter logic [7:0] C_HDR = 8'h20,
    parameter logic [11:0] C_DATA = 12'h100,
    parameter int CFG_AW = 10
) (
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire logic I_CE,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [7:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    input wire logic I_RQ_TVALID,
    input wire logic I_RQ_TLAST,
    input wire logic [DATA_W-1:0] I_REQUEST_DATA_BUS,
    input wire logic [DATA_W/32-1:0] I_REQUEST_DWORD_KEEP,
    input wire logic [UW-1:0] I_REQUEST_USER_SIDEBAND,
    output logic O_RQ_TREADY,
    output logic O_RQ_HDR_VALID,
    output logic [3:0] O_FIRST_DWORD_BYTE_ENABLES,
    output logic [3:0] O_LAST_DWORD_BYTE_ENABLES,
    output logic O_RQ_FORCE_ECRC,
    output logic O_RQ_POISONED,
    output logic O_RQ_DISCONTINUE,
    input wire logic I_NPH_RETURN,
    input wire logic I_NPD_RETURN,
    input wire logic I_TAG_RETURN,
    output logic [7:0] O_NONPOSTED_HEADER_CREDIT_AVAIL,
    output logic [11:0] O_NONPOSTED_PAYLOAD_CREDIT_AVAIL,
    output logic [5:0] O_REQUEST_TAG_AVAIL,
    input wire logic [1:0] I_FC_SEL,
    output logic [7:0] O_FC_HDR,
    output logic [11:0] O_FC_DATA,
    input wire logic I_MSG_REQ,
    input wire logic [2:0] I_MSG_TYPE,
    input wire logic [31:0] I_MSG_DATA,
    output logic O_MSG_DONE,
    input wire logic I_INT_REQ,
    input wire logic [1:0] I_INT_KIND,
    output logic O_INT_SENT,
    output logic O_INT_FAIL,
    input wire logic [CFG_AW-1:0] I_CFG_ADDR,
    input wire logic I_CFG_READ,
    input wire logic I_CFG_WRITE,
    input wire logic [3:0] I_CFG_BE,
    input wire logic [31:0] I_CFG_WDATA,
    output logic [31:0] O_CFG_RDATA,
    output logic O_CFG_DONE,
    output logic O_IRQ
);
    localparam int KW = DATA_W / 32;
    localparam int MSGD = MSG_CYC;
    localparam int INTD = INT_CYC;
    if (DATA_W != 128 && DATA_W != 256) begin : g_chk_w
        $error("data width must be 128 or 256");
    end
    if (UW <= U_DISC) begin : g_chk_u
        $error("user sideband too narrow");
    end
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SYS_RST || !I_CE);

    // ----------------------------------------
    // credit counters
    // ----------------------------------------
    rrs_crd_if #(.W(8)) nph_if();
    rrs_crd_if #(.W(12)) npd_if();
    rrs_crd_if #(.W(6)) tag_if();
    rrs_credit_ctr #(.W(8), .INIT(NPH_INIT)) u_nph (
        .i_clk(I_CLK), .i_rst(I_SYS_RST), .i_ce(I_CE), .cif(nph_if));
    rrs_credit_ctr #(.W(12), .INIT(NPD_INIT)) u_npd (
        .i_clk(I_CLK), .i_rst(I_SYS_RST), .i_ce(I_CE), .cif(npd_if));
    rrs_credit_ctr #(.W(6), .INIT(TAG_INIT)) u_tag (
        .i_clk(I_CLK), .i_rst(I_SYS_RST), .i_ce(I_CE), .cif(tag_if));
    assign O_NONPOSTED_HEADER_CREDIT_AVAIL = nph_if.avail;
    assign O_NONPOSTED_PAYLOAD_CREDIT_AVAIL = npd_if.avail;
    assign O_REQUEST_TAG_AVAIL = tag_if.avail;
    assign nph_if.ret = I_NPH_RETURN;
    assign npd_if.ret = I_NPD_RETURN;
    assign tag_if.ret = I_TAG_RETURN;

    // ----------------------------------------
    // request stream
    // ----------------------------------------
    rrs_rq_st_t st_q, st_d;
    logic rdy_q, rdy_d, np_q, np_d, hv_q, hv_d, ecrc_q, ecrc_d;
    logic pois_q, pois_d, disc_q, disc_d;
    logic [3:0] fbe_q, fbe_d, lbe_q, lbe_d;
    logic acc, sop_acc, np_hdr, disc_in, keep_bad;
    assign acc = I_RQ_TVALID && rdy_q;
    assign sop_acc = acc && st_q == ST_IDLE;
    assign np_hdr = I_REQUEST_DATA_BUS[D_TYPE+:4] != T_MEM_WR;
    assign disc_in = acc && I_REQUEST_USER_SIDEBAND[U_DISC];
    assign keep_bad = acc && !I_RQ_TLAST
        && !rrs_keep_ok(8'(I_REQUEST_DWORD_KEEP));
    assign nph_if.take = sop_acc && np_hdr;
    assign tag_if.take = sop_acc && np_hdr;
    assign npd_if.take = acc && st_q == ST_PKT && np_q;
    always_comb begin
        st_d = st_q;
        np_d = np_q;
        hv_d = 1'b0;
        fbe_d = fbe_q;
        lbe_d = lbe_q;
        ecrc_d = ecrc_q;
        pois_d = pois_q;
        disc_d = disc_in;
        if (sop_acc) begin
            st_d = ST_PKT;
            np_d = np_hdr;
            hv_d = 1'b1;
            fbe_d = I_REQUEST_USER_SIDEBAND[U_FBE+:4];
            lbe_d = I_REQUEST_USER_SIDEBAND[U_LBE+:4];
            ecrc_d = I_REQUEST_DATA_BUS[D_ECRC];
            pois_d = I_REQUEST_DATA_BUS[D_POIS];
        end
        if (acc && (I_RQ_TLAST || disc_in))
            st_d = ST_IDLE;
        // stall a cycle after a header take that ends its packet so credits are settled
        if (st_d == ST_PKT)
            rdy_d = !np_d || npd_if.avail > {11'h000, npd_if.take};
        else
            rdy_d = !sop_acc && nph_if.avail != 8'h00
                && tag_if.avail != 6'h00;
    end
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            st_q <= ST_IDLE;
            rdy_q <= 1'b0;
            np_q <= 1'b0;
            hv_q <= 1'b0;
            fbe_q <= 4'h0;
            lbe_q <= 4'h0;
            ecrc_q <= 1'b0;
            pois_q <= 1'b0;
            disc_q <= 1'b0;
        end else if (I_CE) begin
            st_q <= st_d;
            rdy_q <= rdy_d;
            np_q <= np_d;
            hv_q <= hv_d;
            fbe_q <= fbe_d;
            lbe_q <= lbe_d;
            ecrc_q <= ecrc_d;
            pois_q <= pois_d;
            disc_q <= disc_d;
        end
    end
    assign O_RQ_TREADY = rdy_q;
    assign O_RQ_HDR_VALID = hv_q;
    assign O_FIRST_DWORD_BYTE_ENABLES = fbe_q;
    assign O_LAST_DWORD_BYTE_ENABLES = lbe_q;
    assign O_RQ_FORCE_ECRC = ecrc_q;
    assign O_RQ_POISONED = pois_q;
    assign O_RQ_DISCONTINUE = disc_q;

    // ----------------------------------------
    // flow control, message and interrupt
    // ----------------------------------------
    logic [7:0] fch_q, fch_d;
    logic [11:0] fcd_q, fcd_d;
    logic mbusy_q, mbusy_d, mdone_q, mdone_d, ibusy_q, ibusy_d;
    logic isent_q, isent_d, ifail_q, ifail_d;
    logic [3:0] mcnt_q, mcnt_d, icnt_q, icnt_d;
    logic [2:0] mtyp_q, mtyp_d, ctrl_q;
    logic int_ok;
    assign int_ok = I_INT_KIND != 2'h3 && ctrl_q[I_INT_KIND];
    always_comb begin
        case (I_FC_SEL)
            FC_P: begin
                fch_d = P_HDR;
                fcd_d = P_DATA;
            end
            FC_NP: begin
                fch_d = nph_if.avail;
                fcd_d = npd_if.avail;
            end
            FC_CPL: begin
                fch_d = C_HDR;
                fcd_d = C_DATA;
            end
            default: begin
                fch_d = 8'h00;
                fcd_d = 12'h000;
            end
        endcase
        mbusy_d = mbusy_q;
        mcnt_d = mcnt_q;
        mtyp_d = mtyp_q;
        mdone_d = 1'b0;
        if (!mbusy_q && I_MSG_REQ) begin
            mbusy_d = 1'b1;
            mcnt_d = 4'(MSG_CYC - 1);
            mtyp_d = I_MSG_TYPE;
        end else if (mbusy_q && mcnt_q == 4'h0) begin
            mbusy_d = 1'b0;
            mdone_d = 1'b1;
        end else if (mbusy_q) begin
            mcnt_d = mcnt_q - 4'h1;
        end
        // sent after latency, fail at once
        ibusy_d = ibusy_q;
        icnt_d = icnt_q;
        isent_d = 1'b0;
        ifail_d = 1'b0;
        if (!ibusy_q && I_INT_REQ && !int_ok) begin
            ifail_d = 1'b1;
        end else if (!ibusy_q && I_INT_REQ) begin
            ibusy_d = 1'b1;
            icnt_d = 4'(INT_CYC - 1);
        end else if (ibusy_q && icnt_q == 4'h0) begin
            ibusy_d = 1'b0;
            isent_d = 1'b1;
        end else if (ibusy_q) begin
            icnt_d = icnt_q - 4'h1;
        end
    end
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            fch_q <= 8'h00;
            fcd_q <= 12'h000;
            mbusy_q <= 1'b0;
            mcnt_q <= 4'h0;
            mtyp_q <= 3'h0;
            mdone_q <= 1'b0;
            ibusy_q <= 1'b0;
            icnt_q <= 4'h0;
            isent_q <= 1'b0;
            ifail_q <= 1'b0;
        end else if (I_CE) begin
            fch_q <= fch_d;
            fcd_q <= fcd_d;
            mbusy_q <= mbusy_d;
            mcnt_q <= mcnt_d;
            mtyp_q <= mtyp_d;
            mdone_q <= mdone_d;
            ibusy_q <= ibusy_d;
            icnt_q <= icnt_d;
            isent_q <= isent_d;
            ifail_q <= ifail_d;
        end
    end
    assign O_FC_HDR = fch_q;
    assign O_FC_DATA = fcd_q;
    assign O_MSG_DONE = mdone_q;
    assign O_INT_SENT = isent_q;
    assign O_INT_FAIL = ifail_q;

    // ----------------------------------------
    // configuration management
    // ----------------------------------------
    rrs_mem_if #(.AW(CFG_AW)) cfg_if();
    logic cdone_q, cdone_d;
    assign cfg_if.en = I_CFG_READ || I_CFG_WRITE;
    assign cfg_if.we = I_CFG_WRITE;
    assign cfg_if.be = I_CFG_BE;
    assign cfg_if.addr = I_CFG_ADDR;
    assign cfg_if.wdata = I_CFG_WDATA;
    assign cdone_d = I_CFG_READ || I_CFG_WRITE;
    rrs_cfg_mem #(.AW(CFG_AW)) u_cfg (
        .i_clk(I_CLK), .i_rst(I_SYS_RST), .i_ce(I_CE), .mif(cfg_if));
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST)
            cdone_q <= 1'b0;
        else if (I_CE)
            cdone_q <= cdone_d;
    end
    assign O_CFG_RDATA = cfg_if.rdata;
    assign O_CFG_DONE = cdone_q;

    // ----------------------------------------
    // apb slave and interrupt status
    // ----------------------------------------
    logic [31:0] prd_q, prd_d;
    logic prdy_q, prdy_d, perr_q, perr_d, irq_q, irq_d, wr, map;
    logic [2:0] ctrl_d;
    logic [NSTAT-1:0] stat_q, stat_d, ien_q, ien_d, ev;
    // one wait state; write lands with pready
    assign wr = I_PSEL && I_PENABLE && prdy_q && I_PWRITE && !perr_q;
    assign map = I_PADDR <= A_MSG && I_PADDR[1:0] == 2'h0;
    assign ev = {keep_bad, sop_acc && I_REQUEST_DATA_BUS[D_POIS],
                 disc_in, ifail_d, isent_d, mdone_d};
    always_comb begin
        prdy_d = I_PSEL && I_PENABLE && !prdy_q;
        perr_d = prdy_d && !map;
        prd_d = 32'h0000_0000;
        case (I_PADDR)
            A_CTRL: prd_d[2:0] = ctrl_q;
            A_STAT: prd_d[NSTAT-1:0] = stat_q;
            A_IEN: prd_d[NSTAT-1:0] = ien_q;
            A_CRED: prd_d = {6'h00, tag_if.avail,
                             npd_if.avail, nph_if.avail};
            A_MSG: prd_d = {27'h0, mbusy_q, 1'b0, mtyp_q};
            default: prd_d = 32'h0000_0000;
        endcase
        if (!prdy_d)
            prd_d = prd_q;
        ctrl_d = (wr && I_PADDR == A_CTRL) ? I_PWDATA[2:0] : ctrl_q;
        ien_d = (wr && I_PADDR == A_IEN) ? I_PWDATA[NSTAT-1:0] : ien_q;
        // a new event wins over its clear
        stat_d = stat_q;
        if (wr && I_PADDR == A_CLR)
            stat_d = stat_q & ~I_PWDATA[NSTAT-1:0];
        stat_d = stat_d | ev;
        irq_d = |(stat_d & ien_d);
    end
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            prd_q <= 32'h0000_0000;
            prdy_q <= 1'b0;
            perr_q <= 1'b0;
            ctrl_q <= CTRL_RST;
            ien_q <= '0;
            stat_q <= '0;
            irq_q <= 1'b0;
        end else if (I_CE) begin
            prd_q <= prd_d;
            prdy_q <= prdy_d;
            perr_q <= perr_d;
            ctrl_q <= ctrl_d;
            ien_q <= ien_d;
            stat_q <= stat_d;
            irq_q <= irq_d;
        end
    end
    assign O_PRDATA = prd_q;
    assign O_PREADY = prdy_q;
    assign O_PSLVERR = perr_q;
    assign O_IRQ = irq_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    AST_KEEP_FLAG: assert property (keep_bad |=> stat_q[S_KEEP])
        else $error("bad keep not flagged");
    AST_BYTE_EN: assert property (sop_acc |=>
        O_FIRST_DWORD_BYTE_ENABLES == $past(I_REQUEST_USER_SIDEBAND[3:0])
        && O_LAST_DWORD_BYTE_ENABLES == $past(I_REQUEST_USER_SIDEBAND[7:4])
        && O_RQ_HDR_VALID) else $error("byte enables not captured");
    AST_DESC_FLAGS: assert property (sop_acc |=>
        O_RQ_FORCE_ECRC == $past(I_REQUEST_DATA_BUS[D_ECRC])
        && O_RQ_POISONED == $past(I_REQUEST_DATA_BUS[D_POIS]))
        else $error("descriptor flags wrong");
    AST_DISCONT: assert property (disc_in |=>
        O_RQ_DISCONTINUE && st_q == ST_IDLE)
        else $error("discontinue not honoured");
    AST_SOP_CREDIT: assert property (st_q == ST_IDLE && O_RQ_TREADY
        |-> O_NONPOSTED_HEADER_CREDIT_AVAIL != 8'h00
        && O_REQUEST_TAG_AVAIL != 6'h00) else $error("ready without credit");
    AST_NPD_LIVE: assert property (npd_if.take && !I_NPD_RETURN
        && O_NONPOSTED_PAYLOAD_CREDIT_AVAIL != 12'h000 |=>
        O_NONPOSTED_PAYLOAD_CREDIT_AVAIL
        == $past(O_NONPOSTED_PAYLOAD_CREDIT_AVAIL) - 12'h001)
        else $error("payload credit not updated");
    AST_MSG_DONE: assert property (!mbusy_q && I_MSG_REQ
        |=> !O_MSG_DONE [*1] ##[MSGD:MSGD] O_MSG_DONE)
        else $error("message done latency wrong");
    AST_INT_FAIL: assert property (!ibusy_q && I_INT_REQ && !int_ok
        |=> O_INT_FAIL && !O_INT_SENT) else $error("interrupt fail missing");
    AST_INT_SENT: assert property (!ibusy_q && I_INT_REQ && int_ok
        |=> ##[INTD:INTD] O_INT_SENT) else $error("interrupt sent missing");
    AST_FC_NP: assert property (I_FC_SEL == FC_NP
        |=> O_FC_HDR == $past(O_NONPOSTED_HEADER_CREDIT_AVAIL))
        else $error("flow control select wrong");
    AST_CFG_DONE: assert property ((I_CFG_READ || I_CFG_WRITE)
        |=> O_CFG_DONE ##1 (O_CFG_DONE == $past(I_CFG_READ || I_CFG_WRITE)))
        else $error("config done wrong");
endmodule
`default_nettype wire

// >>> rrs_pkg.sv
// shared constants of the requester request sideband block
// assumes a single 40 MHz user clock with synchronous reset
package rrs_pkg;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_PS = 25000;
    localparam int MSG_LAT_NS = 100;
    localparam int INT_LAT_NS = 200;
    localparam int MSG_CYC = (MSG_LAT_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int INT_CYC = (INT_LAT_NS * 1000 + CLK_PS - 1) / CLK_PS;
    // ----------------------------------------
    // sideband and descriptor positions
    // ----------------------------------------
    localparam int U_FBE = 0;
    localparam int U_LBE = 4;
    localparam int U_DISC = 11;
    localparam int D_ECRC = 127;
    localparam int D_POIS = 79;
    localparam int D_TYPE = 75;
    localparam logic [3:0] T_MEM_WR = 4'h1;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [7:0] A_CLR = 8'h08;
    localparam logic [7:0] A_IEN = 8'h0c;
    localparam logic [7:0] A_CRED = 8'h10;
    localparam logic [7:0] A_MSG = 8'h14;
    localparam int S_MSG = 0;
    localparam int S_SENT = 1;
    localparam int S_FAIL = 2;
    localparam int S_DISC = 3;
    localparam int S_POIS = 4;
    localparam int S_KEEP = 5;
    localparam int NSTAT = 6;
    localparam logic [2:0] CTRL_RST = 3'h7;
    localparam int CR_NPD = 8;
    localparam int CR_TAG = 20;
    localparam int MR_BUSY = 4;
    // ----------------------------------------
    // selections
    // ----------------------------------------
    localparam logic [1:0] FC_P = 2'h0;
    localparam logic [1:0] FC_NP = 2'h1;
    localparam logic [1:0] FC_CPL = 2'h2;
    typedef enum logic {ST_IDLE, ST_PKT} rrs_rq_st_t;
    // contiguous from bit 0, non-empty
    function automatic logic rrs_keep_ok(input logic [7:0] k);
        return (k != 8'h00) && ((k & (k + 8'h01)) == 8'h00);
    endfunction
endpackage

// >>> rrs_if.sv
// carriers between the sideband top and its helpers
// assumes one clock shared by both ends
`timescale 1ns/1ps
`default_nettype none
interface rrs_crd_if #(parameter int W = 8);
    logic take;
    logic ret;
    logic [W-1:0] avail;
    modport ctr(input take, input ret, output avail);
    modport usr(output take, output ret, input avail);
endinterface

interface rrs_mem_if #(parameter int AW = 10);
    logic en;
    logic we;
    logic [3:0] be;
    logic [AW-1:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    modport mem(input en, input we, input be, input addr, input wdata,
                output rdata);
    modport usr(output en, output we, output be, output addr,
                output wdata, input rdata);
endinterface
`default_nettype wire

// >>> rrs_credit_ctr.sv
// one saturating credit counter
// assumes take is only raised while credit remains
`timescale 1ns/1ps
`default_nettype none
module rrs_credit_ctr #(
    parameter int W = 8,
    parameter int INIT = 8
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    rrs_crd_if.ctr cif
);
    if (INIT < 1 || INIT >= (1 << W)) begin : g_chk
        $error("credit init does not fit its width");
    end
    logic [W-1:0] avail_q;
    logic [W-1:0] avail_d;
    always_comb begin
        avail_d = avail_q;
        if (cif.ret && !cif.take && avail_q != '1)
            avail_d = avail_q + 1'b1;
        else if (cif.take && !cif.ret && avail_q != '0)
            avail_d = avail_q - 1'b1;
    end
    always_ff @(posedge i_clk) begin
        if (i_rst)
            avail_q <= W'(INIT);
        else if (i_ce)
            avail_q <= avail_d;
    end
    assign cif.avail = avail_q;
endmodule
`default_nettype wire

// >>> rrs_cfg_mem.sv
// configuration space words with byte enables
// assumes read data is wanted one cycle after the request
`timescale 1ns/1ps
`default_nettype none
module rrs_cfg_mem #(
    parameter int AW = 10
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    rrs_mem_if.mem mif
);
    logic [31:0] mem_q [0:(1<<AW)-1];
    logic [31:0] rdata_q;
    // read returns the old word on a write
    always_ff @(posedge i_clk) begin
        if (i_ce && mif.en) begin
            for (int b = 0; b < 4; b++) begin
                if (mif.we && mif.be[b])
                    mem_q[mif.addr][8*b+:8] <= mif.wdata[8*b+:8];
            end
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_rst)
            rdata_q <= 32'h0000_0000;
        else if (i_ce && mif.en)
            rdata_q <= mem_q[mif.addr];
    end
    assign mif.rdata = rdata_q;
endmodule
`default_nettype wire

// >>> rrs_req_src.sv
// request source model on the user side of the stream
// assumes the block's clock and answers to its tready
`timescale 1ns/1ps
`default_nettype none
module rrs_req_src (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_go,
    input wire logic [3:0] i_keep,
    input wire logic [11:0] i_user,
    input wire logic i_tready,
    output logic o_tvalid,
    output logic o_tlast,
    output logic [127:0] o_data,
    output logic [3:0] o_keep,
    output logic [59:0] o_user
);
    // keep, byte enables, crc and poison bits
    // released lines toggle so stale values never look valid
    // discontinue rides on the final beat only, never on the header
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            {o_tvalid, o_tlast, o_keep} <= 6'h0;
            o_data <= '0;
            o_user <= '0;
        end else if (o_tvalid && i_tready) begin
            o_tlast <= 1'b1;
            o_tvalid <= !o_tlast;
            o_data <= ~o_data;
            o_user <= o_tlast ? ~o_user : {48'h0, i_user[11], 11'h0};
        end else if (i_go && !o_tvalid) begin
            {o_tvalid, o_tlast} <= 2'h2;
            o_data <= {1'b1, 47'h0, 1'b1, 4'h2, 75'h0};
            o_user <= {48'h0, 1'b0, i_user[10:0]};
            o_keep <= i_keep;
        end
    end
endmodule
`default_nettype wire

// >>> tb.sv
// self-checking bench for the request sideband block
// assumes one 40 MHz clock and the partner source model
`timescale 1ns/1ps
`default_nettype none
module tb;
    import rrs_pkg::*;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, cfg_wd = 32'h0, cfg_rdata;
    logic pready, pslverr, tvalid, tlast, tready, err, hdr_v, disc;
    logic go = 1'b0, npd_ret = 1'b0, msg_req = 1'b0, int_req = 1'b0;
    logic cfg_rd = 1'b0, cfg_wr = 1'b0, ecrc, pois, msg_done, irq;
    logic int_sent, int_fail, cfg_done;
    logic [127:0] tdata;
    logic [59:0] tuser;
    logic [3:0] tkeep, fbe, lbe, keep = 4'hf;
    logic [11:0] user = 12'h0, npd, fc_data;
    logic [1:0] fc_sel = 2'h0, int_kind = 2'h0;
    logic [2:0] msg_type = 3'h5;
    logic [9:0] cfg_addr = 10'h0;
    logic [7:0] nph, fc_hdr;
    logic [5:0] tag;
    logic [7:0] fh [4] = '{8'h20, 8'h1e, 8'h20, 8'h00};
    logic [11:0] fd [4] = '{12'h100, 12'h0ff, 12'h100, 12'h000};
    int error_cnt = 0, n_compared = 0, cyc = 0, n = 0;

    rrs_req_sideband dut (
        .I_CLK(clk), .I_SYS_RST(rst), .I_CE(1'b1), .I_PSEL(psel),
        .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .I_RQ_TVALID(tvalid), .I_RQ_TLAST(tlast), .I_REQUEST_DATA_BUS(tdata),
        .I_REQUEST_DWORD_KEEP(tkeep), .I_REQUEST_USER_SIDEBAND(tuser),
        .O_RQ_TREADY(tready), .O_RQ_HDR_VALID(hdr_v),
        .O_FIRST_DWORD_BYTE_ENABLES(fbe), .O_LAST_DWORD_BYTE_ENABLES(lbe),
        .O_RQ_FORCE_ECRC(ecrc), .O_RQ_POISONED(pois), .O_RQ_DISCONTINUE(disc),
        .I_NPH_RETURN(1'b0), .I_NPD_RETURN(npd_ret), .I_TAG_RETURN(1'b0),
        .O_NONPOSTED_HEADER_CREDIT_AVAIL(nph),
        .O_NONPOSTED_PAYLOAD_CREDIT_AVAIL(npd), .O_REQUEST_TAG_AVAIL(tag),
        .I_FC_SEL(fc_sel), .O_FC_HDR(fc_hdr), .O_FC_DATA(fc_data),
        .I_MSG_REQ(msg_req), .I_MSG_TYPE(msg_type), .I_MSG_DATA(32'h1234),
        .O_MSG_DONE(msg_done), .I_INT_REQ(int_req), .I_INT_KIND(int_kind),
        .O_INT_SENT(int_sent), .O_INT_FAIL(int_fail), .I_CFG_ADDR(cfg_addr),
        .I_CFG_READ(cfg_rd), .I_CFG_WRITE(cfg_wr), .I_CFG_BE(4'hf),
        .I_CFG_WDATA(cfg_wd), .O_CFG_RDATA(cfg_rdata), .O_CFG_DONE(cfg_done),
        .O_IRQ(irq));
    rrs_req_src src (.i_clk(clk), .i_rst(rst), .i_go(go), .i_keep(keep),
        .i_user(user), .i_tready(tready), .o_tvalid(tvalid), .o_tlast(tlast),
        .o_data(tdata), .o_keep(tkeep), .o_user(tuser));

    always #12.5 clk = ~clk;
    // hang guard, well above the 120 or so cycles used
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            test_done();
        end
    end

    task automatic test_done();
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one-cycle requests drop after the edge that takes them
    task automatic wt(input int w);
        n = 0;
        do begin
            @(posedge clk);
            {go, msg_req, int_req, cfg_rd, cfg_wr} <= 5'h0;
            n++;
        end while (n < 40 && !(w == 0 ? hdr_v === 1'b1 :
            w == 1 ? msg_done === 1'b1 :
            w == 2 ? (int_sent | int_fail) === 1'b1 : cfg_done === 1'b1));
        chk(n < 40, 1);
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        chk(n < 40, 1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic pkt(input logic [3:0] k, input logic [11:0] u);
        keep <= k;
        user <= u;
        go <= 1'b1;
        wt(0);
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(nph, 32);
        chk(npd, 256);
        chk(tag, 32);
        apb(0, A_CTRL, 0);
        chk(rd, 7);
        pkt(4'hf, 12'h0a5);
        chk({fbe, lbe}, 8'h5a);
        chk({ecrc, pois}, 2'h3);
        chk({nph, tag}, {8'd31, 6'd31});
        repeat (2) @(posedge clk);
        chk(npd, 255);
        npd_ret <= 1'b1;
        @(posedge clk);
        npd_ret <= 1'b0;
        repeat (2) @(posedge clk);
        chk(npd, 256);
        pkt(4'h5, 12'h83c);
        chk({fbe, lbe}, 8'hc3);
        @(posedge clk);
        chk(disc, 1);
        repeat (2) @(posedge clk);
        apb(0, A_STAT, 0);
        chk(rd, 32'h38);
        apb(0, A_CRED, 0);
        chk(rd, 32'h01e0ff1e);
        apb(0, 8'h20, 0);
        chk(err, 1);
        for (int i = 0; i < 4; i++) begin
            fc_sel <= i[1:0];
            repeat (2) @(posedge clk);
            chk({fc_hdr, fc_data}, {fh[i], fd[i]});
        end
        apb(1, A_CLR, 32'h3f);
        msg_req <= 1'b1;
        wt(1);
        apb(0, A_MSG, 0);
        chk(rd & 32'h7, 5);
        chk(irq, 0);
        apb(1, A_IEN, 1);
        repeat (2) @(posedge clk);
        chk(irq, 1);
        apb(1, A_CLR, 1);
        repeat (2) @(posedge clk);
        chk(irq, 0);
        for (int i = 0; i < 5; i++) begin
            if (i == 4) apb(1, A_CTRL, 32'h5);
            int_kind <= (i == 4) ? 2'h1 : i[1:0];
            int_req <= 1'b1;
            wt(2);
            chk({int_sent, int_fail}, (i < 3) ? 2'h2 : 2'h1);
            repeat (2) @(posedge clk);
        end
        cfg_addr <= 10'h3;
        cfg_wd <= 32'ha5c30f96;
        cfg_wr <= 1'b1;
        wt(3);
        @(posedge clk);
        cfg_rd <= 1'b1;
        wt(3);
        chk(cfg_rdata, 32'ha5c30f96);
        test_done();
    end
endmodule
`default_nettype wire
